// *** rtl/fsfm_pkg.sv ***
// Package with fault numbers, codes, field positions and timing constants for the fault monitor.
package fsfm_pkg;
    localparam int unsigned CLK_HZ             = 25000000;
    localparam int unsigned SETPOINT_MARGIN_US = 125;
    localparam int unsigned MARGIN_CYC         = (SETPOINT_MARGIN_US * (CLK_HZ / 1000000));
    localparam int unsigned DWELL_MS_DEF       = 200;
    localparam int unsigned DWELL_CYC_DEF      = DWELL_MS_DEF * (CLK_HZ / 1000);
    localparam logic [15:0] SPEED_SYNC_DEF     = 16'd8000;
    localparam logic [15:0] SPEED_IND_DEF      = 16'd30;
    localparam int unsigned SOL_LSB            = 12;
    localparam int unsigned SOL_MSB            = 15;
    localparam int unsigned SOL_LIM_LSB        = 0;
    localparam int unsigned SOL_LIM_MSB        = 2;
    localparam int unsigned DIAG_WD_BIT        = 3;
    localparam logic [9:0]  F_PUB_LOST         = 10'd596;
    localparam logic [9:0]  F_NOT_SYNC         = 10'd597;
    localparam logic [9:0]  F_SYNC_ERR         = 10'd598;
    localparam logic [9:0]  F_CYC_LOST         = 10'd599;
    localparam logic [9:0]  F_TORQUE_IM        = 10'd602;
    localparam logic [9:0]  F_DSET             = 10'd603;
    localparam logic [9:0]  F_SERIAL           = 10'd604;
    localparam logic [9:0]  F_POS_SAT          = 10'd605;
    localparam logic [9:0]  F_SPD_LIM          = 10'd608;
    localparam logic [9:0]  F_ENC_FREQ         = 10'd609;
    localparam logic [7:0]  C_SOL              = 8'h01;
    localparam logic [7:0]  C_GC               = 8'h02;
    localparam logic [7:0]  C_FIRST_GC         = 8'h01;
    localparam logic [7:0]  C_PLL              = 8'h02;
    localparam logic [7:0]  C_GC_SYNC          = 8'h03;
    localparam logic [7:0]  C_LATE             = 8'h06;
    localparam int unsigned NFLT               = 10;
    localparam int unsigned IDX_PUB            = 0;
    localparam int unsigned IDX_NSY            = 1;
    localparam int unsigned IDX_SYE            = 2;
    localparam int unsigned IDX_CYC            = 3;
    localparam int unsigned IDX_TIM            = 4;
    localparam int unsigned IDX_DSE            = 5;
    localparam int unsigned IDX_SER            = 6;
    localparam int unsigned IDX_POS            = 7;
    localparam int unsigned IDX_SPD            = 8;
    localparam int unsigned IDX_ENC            = 9;
    localparam logic [9:0]  FLT_NUM [NFLT]     = '{F_PUB_LOST, F_NOT_SYNC, F_SYNC_ERR, F_CYC_LOST, F_TORQUE_IM,
                                                   F_DSET, F_SERIAL, F_POS_SAT, F_SPD_LIM, F_ENC_FREQ};
    typedef enum logic [1:0] {FSFM_IDLE, FSFM_WAIT_GC, FSFM_SYNCING, FSFM_RUN} fsfm_sync_t;
endpackage

// *** rtl/fsfm_flt_if.sv ***
// Interface carrying fault raise requests into the fault memory.
`timescale 1ns/1ps
interface fsfm_flt_if;
    import fsfm_pkg::*;
    logic [NFLT-1:0] raise;
    logic [7:0]      code [NFLT];
    logic [NFLT-1:0] ack_ok;
    logic            ack;
    logic [NFLT-1:0] latched;
    logic [7:0]      mem_code [NFLT];
    modport src (output raise, output code, output ack_ok, output ack, input latched, input mem_code);
    modport mem (input raise, input code, input ack_ok, input ack, output latched, output mem_code);
endinterface

// *** rtl/fsfm_fault_mem.sv ***
// Fault memory that latches each fault with its supplementary code.
`timescale 1ns/1ps
module fsfm_fault_mem
    import fsfm_pkg::*;
(
    input  wire logic clk,
    input  wire logic resetn,
    fsfm_flt_if.mem   f
);
    logic [NFLT-1:0] lat_q;
    logic [NFLT-1:0] lat_d;
    logic [7:0]      code_q [NFLT];
    logic [7:0]      code_d [NFLT];

    always_comb
    begin
        for (int i = 0; i < NFLT; i++)
        begin
            lat_d[i]  = lat_q[i];
            code_d[i] = code_q[i];
            if (f.ack && f.ack_ok[i])
            begin
                lat_d[i] = 1'b0;
            end
            // A new event wins over an acknowledge in the same cycle.
            if (f.raise[i])
            begin
                lat_d[i] = 1'b1;
                if (!lat_q[i])
                begin
                    code_d[i] = f.code[i];
                end
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            lat_q <= '0;
            for (int i = 0; i < NFLT; i++)
            begin
                code_q[i] <= 8'h00;
            end
        end
        else
        begin
            lat_q  <= lat_d;
            code_q <= code_d;
        end
    end

    assign f.latched  = lat_q;
    assign f.mem_code = code_q;
endmodule // fsfm_fault_mem

// *** rtl/fsfm_monitor.sv ***
// Fieldbus synchronization and drive-side fault monitor top level.
`timescale 1ns/1ps
module fsfm_monitor
    import fsfm_pkg::*;
#(
    parameter int unsigned WAIT_CYC   = 250000,
    parameter int unsigned PLL_CYC    = 250000,
    parameter int unsigned WDOG_CYC   = 2500000,
    parameter int unsigned GC_FAILS   = 3,
    parameter int unsigned DWELL_CYC  = DWELL_CYC_DEF,
    parameter int unsigned TW         = 24
)
(
    input  wire logic             clk,
    input  wire logic             resetn,
    input  wire logic             cyc_ok,
    input  wire logic             cyc_miss,
    input  wire logic             prm_rx,
    input  wire logic             master_clear,
    input  wire logic             pub_ok,
    input  wire logic             pub_miss,
    input  wire logic [6:0]       pub_addr,
    input  wire logic             prm_watchdog_on,
    input  wire logic             iso_enable,
    input  wire logic             dp_tick,
    input  wire logic             gc_rx,
    input  wire logic             gc_off_grid,
    input  wire logic             pll_locked,
    input  wire logic [15:0]      control_word_two,
    input  wire logic [7:0]       fieldbus_config_param,
    input  wire logic             setpoint_rx,
    input  wire logic [TW-1:0]    output_time,
    input  wire logic             passive_axis_select,
    input  wire logic             torque_mode_sel,
    input  wire logic             encoderless_induction_mode,
    input  wire logic             dset_change,
    input  wire logic             dset_valid,
    input  wire logic             serial_valid,
    input  wire logic [31:0]      serial_read,
    input  wire logic [31:0]      serial_stored,
    input  wire logic [15:0]      pos_speed_req,
    input  wire logic [15:0]      max_motor_speed,
    input  wire logic             spd_at_limit,
    input  wire logic [15:0]      actual_speed,
    input  wire logic [TW-1:0]    limit_dwell_time,
    input  wire logic [15:0]      limit_speed_threshold,
    input  wire logic [31:0]      enc_freq,
    input  wire logic [31:0]      enc_limit_freq,
    input  wire logic             fault_reset,
    output logic [15:0]           slave_diag_word,
    output logic [NFLT-1:0]       fault_active,
    output logic [9:0]            fault_number,
    output logic [7:0]            fault_code,
    output logic                  stop_two
);
    fsfm_flt_if fi ();
    fsfm_sync_t st_q, st_d;
    logic [TW-1:0] wait_q, wait_d, slot_q, slot_d;
    logic [TW-1:0] wd_q, wd_d, dwell_q, dwell_d;
    logic [2:0]    gcf_q, gcf_d;
    logic [3:0]    solf_q, solf_d;
    logic [3:0]    sol_q, sol_d;
    logic          sol_seen_q, sol_seen_d;
    logic          cyc_run_q, cyc_run_d, pub_run_q, pub_run_d, late_q, late_d;
    logic [NFLT-1:0] raise;
    logic [7:0]    sye_code, nsy_code;
    logic [9:0]    num_o;
    logic [7:0]    code_o;

    function automatic logic [TW-1:0] sat_inc(input logic [TW-1:0] v);
        sat_inc = (v == {TW{1'b1}}) ? v : v + 1'b1;
    endfunction

    always_comb
    begin
        st_d       = st_q;
        wait_d     = wait_q;
        slot_d     = dp_tick ? '0 : sat_inc(slot_q);
        wd_d       = cyc_ok ? '0 : sat_inc(wd_q);
        gcf_d      = gcf_q;
        solf_d     = solf_q;
        sol_d      = sol_q;
        sol_seen_d = sol_seen_q;
        cyc_run_d  = cyc_run_q;
        pub_run_d  = pub_run_q;
        late_d     = 1'b0;
        dwell_d    = (spd_at_limit && actual_speed < limit_speed_threshold) ? sat_inc(dwell_q) : '0;
        raise      = '0;
        sye_code   = C_FIRST_GC;
        nsy_code   = C_GC;
        if (cyc_ok)
        begin
            cyc_run_d = 1'b1;
        end
        if (pub_ok)
        begin
            pub_run_d = 1'b1;
        end
        if (pub_miss && pub_run_q)
        begin
            pub_run_d      = 1'b0;
            raise[IDX_PUB] = 1'b1;
        end
        if (cyc_run_q && (cyc_miss || prm_rx || master_clear))
        begin
            cyc_run_d      = 1'b0;
            raise[IDX_CYC] = 1'b1;
        end
        if (prm_watchdog_on && cyc_run_q && wd_q >= TW'(WDOG_CYC))
        begin
            cyc_run_d      = 1'b0;
            raise[IDX_CYC] = 1'b1;
        end
        unique case (st_q)
            FSFM_IDLE:
            begin
                wait_d = '0;
                gcf_d  = '0;
                if (iso_enable)
                begin
                    st_d = FSFM_WAIT_GC;
                end
            end
            FSFM_WAIT_GC:
            begin
                wait_d = sat_inc(wait_q);
                if (gc_rx)
                begin
                    st_d   = FSFM_SYNCING;
                    wait_d = '0;
                end
                else if (wait_q >= TW'(WAIT_CYC))
                begin
                    raise[IDX_SYE] = 1'b1;
                    st_d           = FSFM_IDLE;
                end
            end
            FSFM_SYNCING:
            begin
                wait_d = sat_inc(wait_q);
                if (dp_tick)
                begin
                    gcf_d = gc_rx ? 3'd0 : gcf_q + 3'd1;
                end
                if (gcf_q >= 3'(GC_FAILS))
                begin
                    raise[IDX_SYE] = 1'b1;
                    sye_code       = C_GC_SYNC;
                    st_d           = FSFM_IDLE;
                end
                else if (pll_locked)
                begin
                    st_d  = FSFM_RUN;
                    gcf_d = '0;
                end
                else if (wait_q >= TW'(PLL_CYC))
                begin
                    raise[IDX_SYE] = 1'b1;
                    sye_code       = C_PLL;
                    st_d           = FSFM_IDLE;
                end
            end
            FSFM_RUN:
            begin
                if (dp_tick)
                begin
                    gcf_d = (gc_rx && !gc_off_grid) ? 3'd0 : gcf_q + 3'd1;
                    sol_seen_d = 1'b0;
                    if (sol_seen_q)
                    begin
                        solf_d = '0;
                    end
                    else
                    begin
                        solf_d = solf_q + 4'd1;
                    end
                end
                if (setpoint_rx)
                begin
                    sol_d = control_word_two[SOL_MSB:SOL_LSB];
                    if (control_word_two[SOL_MSB:SOL_LSB] == sol_q + 4'd1)
                    begin
                        sol_seen_d = 1'b1;
                    end
                    late_d = (slot_q + TW'(MARGIN_CYC)) > output_time;
                end
                if (solf_q > fieldbus_config_param[SOL_LIM_MSB:SOL_LIM_LSB])
                begin
                    raise[IDX_NSY] = 1'b1;
                    nsy_code       = C_SOL;
                    solf_d         = '0;
                    st_d           = FSFM_IDLE;
                end
                else if (gcf_q >= 3'(GC_FAILS))
                begin
                    raise[IDX_NSY] = 1'b1;
                    st_d           = FSFM_IDLE;
                end
            end
        endcase
        // Leaving isochronous mode abandons any sync attempt, so no stale timeout fires later.
        if (!iso_enable)
        begin
            st_d = FSFM_IDLE;
        end
        if (late_q)
        begin
            raise[IDX_SYE] = 1'b1;
            sye_code       = C_LATE;
        end
        raise[IDX_TIM] = torque_mode_sel && encoderless_induction_mode;
        raise[IDX_DSE] = dset_change && !dset_valid;
        raise[IDX_SER] = serial_valid && (serial_read != serial_stored);
        raise[IDX_POS] = pos_speed_req > max_motor_speed;
        raise[IDX_SPD] = dwell_q > limit_dwell_time;
        raise[IDX_ENC] = enc_freq > enc_limit_freq;
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            st_q       <= FSFM_IDLE;
            wait_q     <= '0;
            slot_q     <= '0;
            wd_q       <= '0;
            dwell_q    <= '0;
            gcf_q      <= '0;
            solf_q     <= '0;
            sol_q      <= 4'h0;
            sol_seen_q <= 1'b1;
            cyc_run_q  <= 1'b0;
            pub_run_q  <= 1'b0;
            late_q     <= 1'b0;
        end
        else
        begin
            st_q       <= st_d;
            wait_q     <= wait_d;
            slot_q     <= slot_d;
            wd_q       <= wd_d;
            dwell_q    <= dwell_d;
            gcf_q      <= gcf_d;
            solf_q     <= solf_d;
            sol_q      <= sol_d;
            sol_seen_q <= sol_seen_d;
            cyc_run_q  <= cyc_run_d;
            pub_run_q  <= pub_run_d;
            late_q     <= late_d;
        end
    end

    always_comb
    begin
        fi.raise  = raise;
        fi.ack    = fault_reset;
        fi.ack_ok = '1;
        for (int i = 0; i < NFLT; i++)
        begin
            fi.code[i] = 8'h00;
        end
        fi.code[IDX_PUB] = {1'b0, pub_addr};
        fi.code[IDX_NSY] = nsy_code;
        fi.code[IDX_SYE] = sye_code;
        fi.ack_ok[IDX_PUB] = pub_run_q && cyc_run_q;
        fi.ack_ok[IDX_CYC] = cyc_run_q && !passive_axis_select;
    end

    fsfm_fault_mem u_mem (
        .clk    (clk),
        .resetn (resetn),
        .f      (fi)
    );

    // Lowest index wins so the bus faults are reported ahead of drive faults.
    always_comb
    begin
        num_o  = 10'd0;
        code_o = 8'h00;
        for (int i = NFLT - 1; i >= 0; i--)
        begin
            if (fi.latched[i])
            begin
                num_o  = FLT_NUM[i];
                code_o = fi.mem_code[i];
            end
        end
    end

    assign fault_active = fi.latched;
    assign fault_number = num_o;
    assign fault_code   = code_o;
    assign stop_two = fi.latched[IDX_SYE];
    assign slave_diag_word = {12'h000, prm_watchdog_on, 3'b000};
endmodule // fsfm_monitor

// *** dv/fsfm_monitor_properties.sv ***
// Port-level concurrent checks for the fault monitor.
`timescale 1ns/1ps
module fsfm_monitor_props
    import fsfm_pkg::*;
(
    input wire logic                      clk,
    input wire logic                      resetn,
    input wire logic                      prm_watchdog_on,
    input wire logic                      passive_axis_select,
    input wire logic                      torque_mode_sel,
    input wire logic                      encoderless_induction_mode,
    input wire logic                      dset_change,
    input wire logic                      dset_valid,
    input wire logic                      serial_valid,
    input wire logic [31:0]               serial_read,
    input wire logic [31:0]               serial_stored,
    input wire logic [15:0]               pos_speed_req,
    input wire logic [15:0]               max_motor_speed,
    input wire logic [31:0]               enc_freq,
    input wire logic [31:0]               enc_limit_freq,
    input wire logic                      fault_reset,
    input wire logic [15:0]               slave_diag_word,
    input wire logic [fsfm_pkg::NFLT-1:0] fault_active,
    input wire logic [9:0]                fault_number,
    input wire logic [7:0]                fault_code,
    input wire logic                      stop_two
);
    default clocking dcb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    a_dset_unparam: assert property (dset_change && !dset_valid |=> fault_active[IDX_DSE])
        else $error("data set changeover fault not latched");
    a_serial_mismatch: assert property (serial_valid && serial_read != serial_stored |=> fault_active[IDX_SER])
        else $error("encoder serial fault not latched");
    a_pos_overspeed: assert property (pos_speed_req > max_motor_speed |=> fault_active[IDX_POS])
        else $error("position controller fault not latched");
    a_enc_overrun: assert property (enc_freq > enc_limit_freq |=> fault_active[IDX_ENC])
        else $error("encoder frequency fault not latched");
    a_torque_im: assert property (torque_mode_sel && encoderless_induction_mode |=> fault_active[IDX_TIM])
        else $error("torque mode fault not latched");
    a_diag_bit: assert property (slave_diag_word == {12'h000, prm_watchdog_on, 3'h0})
        else $error("diagnostic word does not show watchdog state");
    a_stop_sync: assert property (stop_two == fault_active[IDX_SYE])
        else $error("fixed stop does not follow synchronization fault");
    a_latch_hold: assert property (!fault_reset |=> (fault_active & $past(fault_active)) == $past(fault_active))
        else $error("fault cleared without acknowledge");
    a_passive_hold: assert property (fault_active[IDX_CYC] && passive_axis_select |=> fault_active[IDX_CYC])
        else $error("passive axis cyclic fault was acknowledged");
    a_none_zero: assert property (fault_active == '0 |-> fault_number == 10'h0 && fault_code == 8'h00)
        else $error("fault number shown with no fault latched");
endmodule // fsfm_monitor_props

bind fsfm_monitor fsfm_monitor_props fsfm_monitor_props_inst (.clk, .resetn, .prm_watchdog_on,
    .passive_axis_select, .torque_mode_sel, .encoderless_induction_mode, .dset_change, .dset_valid,
    .serial_valid, .serial_read, .serial_stored, .pos_speed_req, .max_motor_speed, .enc_freq,
    .enc_limit_freq, .fault_reset, .slave_diag_word, .fault_active, .fault_number, .fault_code, .stop_two);

// *** dv/fsfm_master_model.sv ***
// Behavioural bus master and publisher that feed the fault monitor.
`timescale 1ns/1ps
module fsfm_master_model
(
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic       run,
    input  wire logic       drop_cyc,
    input  wire logic       drop_pub,
    input  wire logic       drop_gc,
    input  wire logic       bad_sol,
    input  wire logic [7:0] sp_dly,
    output logic            cyc_ok,
    output logic            cyc_miss,
    output logic            pub_ok,
    output logic            pub_miss,
    output logic            dp_tick,
    output logic            gc_rx,
    output logic            setpoint_rx,
    output logic [15:0]     control_word_two
);
    logic       act;
    logic [4:0] cnt;

    initial
    begin
        {cyc_ok, cyc_miss, pub_ok, pub_miss, dp_tick, gc_rx, setpoint_rx, act} = '0;
        control_word_two = 16'h0000;
        cnt = 5'h00;
    end

    // A DP cycle is 32 clocks; frames go out at fixed offsets within it, except the setpoint, whose offset is sp_dly.
    // Outputs move by non-blocking assignment so the monitor, sampling on the same edge, never races these changes.
    always @(posedge clk)
    begin
        act = resetn && run;
        dp_tick <= act && cnt == 5'h00;
        gc_rx <= act && cnt == 5'h00 && !drop_gc;
        if (act && cnt == 5'h00 && !bad_sol)
            control_word_two[15:12] <= control_word_two[15:12] + 4'h1;
        cyc_ok <= act && cnt == 5'h04 && !drop_cyc;
        cyc_miss <= act && cnt == 5'h04 && drop_cyc;
        pub_ok <= act && cnt == 5'h06 && !drop_pub;
        pub_miss <= act && cnt == 5'h06 && drop_pub;
        setpoint_rx <= act && cnt == sp_dly[4:0];
        cnt <= act ? cnt + 5'h01 : 5'h00;
    end
endmodule // fsfm_master_model

// *** dv/fsfm_monitor_test.sv ***
// Self-checking bench for the fieldbus sync fault monitor.
`timescale 1ns/1ps
module fsfm_monitor_test;
    import fsfm_pkg::*;
    logic        clk, resetn, cyc_ok, cyc_miss, prm_rx, master_clear, pub_ok, pub_miss, dp_tick, gc_rx;
    logic        prm_watchdog_on, iso_enable, gc_off_grid, pll_locked, setpoint_rx, passive_axis_select;
    logic        torque_mode_sel, encoderless_induction_mode, dset_change, dset_valid, serial_valid;
    logic        spd_at_limit, fault_reset, stop_two, run, drop_cyc, drop_pub, drop_gc, bad_sol;
    logic [6:0]  pub_addr;
    logic [7:0]  fieldbus_config_param, fault_code, sp_dly;
    logic [9:0]  fault_number;
    logic [15:0] control_word_two, pos_speed_req, max_motor_speed, actual_speed, limit_speed_threshold;
    logic [15:0] slave_diag_word;
    logic [23:0] output_time, limit_dwell_time;
    logic [31:0] serial_read, serial_stored, enc_freq, enc_limit_freq;
    logic [NFLT-1:0] fault_active;
    int          miscompares, n_compared, cycles;
    int          dix [6] = '{IDX_TIM, IDX_DSE, IDX_SER, IDX_POS, IDX_ENC, IDX_SPD};

    fsfm_monitor #(.WAIT_CYC(50), .PLL_CYC(50), .WDOG_CYC(50), .GC_FAILS(3), .TW(24)) fsfm_monitor_inst (
        .clk, .resetn, .cyc_ok, .cyc_miss, .prm_rx, .master_clear, .pub_ok, .pub_miss, .pub_addr,
        .prm_watchdog_on, .iso_enable, .dp_tick, .gc_rx, .gc_off_grid, .pll_locked, .control_word_two,
        .fieldbus_config_param, .setpoint_rx, .output_time, .passive_axis_select, .torque_mode_sel,
        .encoderless_induction_mode, .dset_change, .dset_valid, .serial_valid, .serial_read, .serial_stored,
        .pos_speed_req, .max_motor_speed, .spd_at_limit, .actual_speed, .limit_dwell_time,
        .limit_speed_threshold, .enc_freq, .enc_limit_freq, .fault_reset, .slave_diag_word, .fault_active,
        .fault_number, .fault_code, .stop_two);

    fsfm_master_model fsfm_master_model_inst (.clk, .resetn, .run, .drop_cyc, .drop_pub, .drop_gc, .bad_sol,
        .sp_dly, .cyc_ok, .cyc_miss, .pub_ok, .pub_miss, .dp_tick, .gc_rx, .setpoint_rx, .control_word_two);

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic report_and_stop();
        if (miscompares == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic ack();
        fault_reset = 1'b1;
        tick(1);
        fault_reset = 1'b0;
        tick(1);
    endtask

    task automatic wait_flt(input int idx, input int lim);
        int n;
        n = 0;
        while (fault_active[idx] !== 1'b1 && n < lim)
        begin
            tick(1);
            n++;
        end
        check("fault_active bit", fault_active[idx], 1'b1);
    endtask

    task automatic setc(input int k, input logic v);
        case (k)
            0: {torque_mode_sel, encoderless_induction_mode} = {v, v};
            1: {dset_change, dset_valid} = {v, !v};
            2: {serial_valid, serial_read} = {v, serial_stored ^ {31'h0, v}};
            3: pos_speed_req = max_motor_speed + {15'h0, v};
            4: enc_freq = enc_limit_freq + {31'h0, v};
            default: spd_at_limit = v;
        endcase
    endtask

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // A hang is cut short well beyond the expected run length.
    always @(posedge clk)
    begin
        cycles++;
        if (cycles >= 20000)
        begin
            miscompares++;
            report_and_stop();
        end
    end

    initial
    begin
        {miscompares, n_compared, cycles} = '0;
        {resetn, prm_rx, master_clear, prm_watchdog_on, iso_enable, gc_off_grid, pll_locked} = '0;
        {passive_axis_select, torque_mode_sel, encoderless_induction_mode, dset_change, serial_valid} = '0;
        {spd_at_limit, fault_reset, run, drop_cyc, drop_pub, drop_gc, bad_sol, actual_speed} = '0;
        {dset_valid, pub_addr, sp_dly, fieldbus_config_param} = {1'b1, 7'h2a, 8'h08, 8'h03};
        {serial_read, serial_stored} = {32'h0000_1234, 32'h0000_1234};
        {pos_speed_req, max_motor_speed} = {16'h1000, 16'h1000};
        {enc_freq, enc_limit_freq} = {32'h0001_0000, 32'h0001_0000};
        {limit_dwell_time, limit_speed_threshold} = {24'h000014, SPEED_IND_DEF};
        output_time = 24'(MARGIN_CYC + 16);
        tick(3);
        check("fault_active", fault_active, 10'h0);
        check("stop_two", stop_two, 1'b0);
        resetn = 1'b1;
        for (int v = 0; v < 2; v++)
        begin
            prm_watchdog_on = v[0];
            #1;
            check("slave_diag_word", slave_diag_word, {28'h0, v[0], 3'h0});
        end
        tick(1);
        for (int k = 0; k < 6; k++)
        begin
            setc(k, 1'b1);
            tick(k == 5 ? 30 : 1);
            setc(k, 1'b0);
            tick(2);
            check("fault_active", fault_active, 10'h1 << dix[k]);
            check("fault_number", fault_number, FLT_NUM[dix[k]]);
            ack();
            check("fault_active", fault_active, 10'h0);
        end
        iso_enable = 1'b1;
        wait_flt(IDX_SYE, 80);
        check("fault_code", fault_code, C_FIRST_GC);
        check("stop_two", stop_two, 1'b1);
        iso_enable = 1'b0;
        ack();
        check("stop_two", stop_two, 1'b0);
        run = 1'b1;
        tick(40);
        iso_enable = 1'b1;
        wait_flt(IDX_SYE, 150);
        check("fault_code", fault_code, C_PLL);
        iso_enable = 1'b0;
        ack();
        pll_locked = 1'b1;
        for (int k = 0; k < 4; k++)
        begin
            iso_enable = 1'b1;
            tick(200);
            check("fault_active", fault_active, 10'h0);
            case (k)
                0: drop_gc = 1'b1;
                1: bad_sol = 1'b1;
                2: sp_dly = 8'h18;
                default: gc_off_grid = 1'b1;
            endcase
            wait_flt(k == 2 ? IDX_SYE : IDX_NSY, 300);
            check("fault_code", fault_code, k == 1 ? C_SOL : k == 2 ? C_LATE : C_GC);
            {drop_gc, bad_sol, gc_off_grid, iso_enable, sp_dly} = {4'h0, 8'h08};
            tick(2);
            ack();
        end
        drop_cyc = 1'b1;
        wait_flt(IDX_CYC, 80);
        {passive_axis_select, drop_cyc} = 2'b10;
        tick(40);
        ack();
        check("fault_active bit", fault_active[IDX_CYC], 1'b1);
        passive_axis_select = 1'b0;
        ack();
        check("fault_active bit", fault_active[IDX_CYC], 1'b0);
        for (int k = 0; k < 3; k++)
        begin
            {prm_rx, master_clear, run} = {k == 0, k == 1, k != 2};
            if (k == 2)
                wait_flt(IDX_CYC, 60);
            tick(1);
            {prm_rx, master_clear, run} = 3'b001;
            tick(1);
            check("fault_active bit", fault_active[IDX_CYC], 1'b1);
            tick(40);
            ack();
            check("fault_active bit", fault_active[IDX_CYC], 1'b0);
        end
        drop_pub = 1'b1;
        wait_flt(IDX_PUB, 80);
        check("fault_code", fault_code, {1'b0, pub_addr});
        ack();
        check("fault_active bit", fault_active[IDX_PUB], 1'b1);
        drop_pub = 1'b0;
        tick(40);
        ack();
        check("fault_active bit", fault_active[IDX_PUB], 1'b0);
        report_and_stop();
    end
endmodule // fsfm_monitor_test
